// *** common/nbus_regs.svh ***
// Named field codes and counts of the nibble bus target.
// Assumes inclusion by bare name from design files.
`ifndef NBUS_REGS_SVH
`define NBUS_REGS_SVH

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define NB_START_READ 4'hd
`define NB_START_WRITE 4'he
`define NB_SIZE_ONE 4'h0
`define NB_WAIT_SYNC 4'h5
`define NB_READY_SYNC 4'h0
`define NB_TURN_ONES 4'hf

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define NB_ADDR_LAST 3'h6
`define NB_ADDR_FIRST 3'h0
`define NB_BUF_DEPTH 2'h2
`define NB_BUF_EMPTY 2'h0

`endif

// *** common/nbus_pkg.sv ***
// Types shared by the nibble bus target and its read data buffer.
// Assumes no other package.
package nbus_pkg;

    // ----------------------------------------------------------------
    // Protocol states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE  = 4'h0,
        S_START = 4'h1,
        S_ADDR  = 4'h2,
        S_SIZE  = 4'h3,
        S_WLO   = 4'h4,
        S_WHI   = 4'h5,
        S_WAIT  = 4'h6,
        S_READY_SYNC_CODE = 4'h7,
        S_DLO   = 4'h8,
        S_DHI   = 4'h9,
        S_TAR   = 4'ha,
        S_SKIP  = 4'hb
    } nb_state_t;

    typedef logic [3:0] nibble_t;
    typedef logic [7:0] byte_t;
    typedef logic [27:0] mem_addr_t;

endpackage

// *** common/byte_stream_if.sv ***
// Valid/ready byte stream between the target and its buffer.
// Assumes both ends on the same clock.
`timescale 1ns/1ps
interface byte_stream_if;
    import nbus_pkg::*;
    byte_t data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// *** logic/pair_buffer.sv ***
// Two-entry byte buffer with valid/ready on both sides and a flush.
// Assumes a synchronous, already released active-low reset copy.
`timescale 1ns/1ps
module pair_buffer
    import nbus_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_flush,
    byte_stream_if.snk fill,
    byte_stream_if.src drain
);
`include "nbus_regs.svh"

    byte_t mem_r [2];
    byte_t mem_nxt [2];
    logic wr_ptr_r, wr_ptr_nxt;
    logic rd_ptr_r, rd_ptr_nxt;
    logic [1:0] count_r, count_nxt;
    logic ready_r, ready_nxt;
    logic push, pop;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Ready is registered so the source sees it straight from a flop
    always_comb begin
        push = fill.valid && ready_r;
        pop = drain.ready && (count_r != `NB_BUF_EMPTY);
        mem_nxt = mem_r;
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt = count_r;
        if (push) begin
            mem_nxt[wr_ptr_r] = fill.data;
            wr_ptr_nxt = ~wr_ptr_r;
        end
        if (pop) begin
            rd_ptr_nxt = ~rd_ptr_r;
        end
        count_nxt = count_r + {1'b0, push} - {1'b0, pop};
        if (i_flush) begin
            wr_ptr_nxt = 1'b0;
            rd_ptr_nxt = 1'b0;
            count_nxt = `NB_BUF_EMPTY;
        end
        ready_nxt = (count_nxt != `NB_BUF_DEPTH);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mem_r[0] <= 8'h00;
            mem_r[1] <= 8'h00;
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
            ready_r <= 1'b0;
        end else begin
            mem_r <= mem_nxt;
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            ready_r <= ready_nxt;
        end
    end

    // Drain side: oldest entry
    assign drain.valid = (count_r != `NB_BUF_EMPTY);
    assign drain.data = mem_r[rd_ptr_r];
    assign fill.ready = ready_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    buf_no_overfill_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        count_r <= `NB_BUF_DEPTH) else $error("buffer count above depth");
    buf_full_stall_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (count_r == `NB_BUF_DEPTH) |-> !ready_r) else $error("ready while full");
endmodule

// *** logic/nibble_bus_target.sv ***
// Target end of a 4-bit multiplexed flash host bus: read and write cycles.
// Assumes host pins asynchronous to i_clk, one field per i_clk on the pins,
// and a memory core that answers read requests through i_rdata_*.
//
// Function
// RULE_01 - Respond only when start field comes with frame strobe low.
// RULE_02 - Of several start fields under low strobe, only the last counts.
// RULE_03 - Start code 1101 in first clock decodes as memory read.
// RULE_04 - Act on cycle only when device-select nibble equals strapped identity.
// RULE_05 - 28-bit address from seven nibbles, most significant first, assembled so.
// RULE_06 - Host clears low address bits for multibyte transfers.
// RULE_07 - Size field in clock 10; only 0000, one byte, supported.
// RULE_08 - Host drives 1111 in clock 11 then floats the bus.
// RULE_09 - Device takes over floating bus in clock 12.
// RULE_10 - Device drives wait-sync 0101 for two clocks, 13 and 14; code keeps driving it past clock 14 while a slow core has no byte ready.
// RULE_11 - Device drives ready-sync 0000 in clock 15.
// RULE_12 - Low data nibble in clock 16, high nibble in clock 17.
// RULE_13 - Never emit further bytes; only single-byte size supported.
// RULE_14 - After last data nibble drive 1111, then release the bus.
// RULE_15 - Host resumes driving after device release, ending the cycle.
// RULE_16 - Fields valid and sampled on the rising clock edge.
// RULE_17 - Write cycles carry exactly one byte, data or flash command.
// RULE_18 - Frame strobe low releases outputs and resets protocol state at once; code does so three clocks after the pin falls, behind the synchroniser.
// RULE_19 - Size other than 0000 resets state; no operation, no response.
// RULE_20 - Every field is one nibble per clock; some span several clocks.
// RULE_21 - On select mismatch stay released and wait for next start.
`timescale 1ns/1ps
module nibble_bus_target
    import nbus_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_frame_strobe_n,
    input wire logic [3:0] i_nibble_bus,
    output logic [3:0] o_nibble_bus,
    output logic o_nibble_bus_oe,
    input wire logic [3:0] i_strapped_identity,
    output logic o_rd_req,
    output logic [27:0] o_mem_addr,
    input wire logic [7:0] i_rdata,
    input wire logic i_rdata_valid,
    output logic o_rdata_ready,
    output logic o_wr_valid,
    output logic [7:0] o_wr_data
);
`include "nbus_regs.svh"

    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic rst_meta_r, rst_n_r;
    logic frame_meta_r, frame_s_r;
    nibble_t nib_meta_r, nib_s_r;
    nibble_t id_meta_r, id_s_r;

    // Reset asserts at once, releases after two edges
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // Two flops on every pin; strobe idles high so resets to high
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            frame_meta_r <= 1'b1;
            frame_s_r <= 1'b1;
            nib_meta_r <= 4'hf;
            nib_s_r <= 4'hf;
            id_meta_r <= 4'h0;
            id_s_r <= 4'h0;
        end else begin
            frame_meta_r <= i_frame_strobe_n;
            frame_s_r <= frame_meta_r; // RULE_16
            nib_meta_r <= i_nibble_bus;
            nib_s_r <= nib_meta_r; // RULE_20
            id_meta_r <= i_strapped_identity;
            id_s_r <= id_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // Read data buffer
    // ----------------------------------------------------------------
    byte_stream_if fill_bus ();
    byte_stream_if drain_bus ();
    logic flush;

    assign fill_bus.data = i_rdata;
    assign fill_bus.valid = i_rdata_valid;

    // Stale data from an aborted read is dropped when a new cycle begins
    pair_buffer u_buf (
        .i_clk(i_clk),
        .i_rst_n(rst_n_r),
        .i_flush(flush),
        .fill(fill_bus),
        .drain(drain_bus)
    );

    // ----------------------------------------------------------------
    // Protocol state machine
    // ----------------------------------------------------------------
    nb_state_t st_r, st_nxt;
    nibble_t start_r, start_nxt;
    mem_addr_t addr_r, addr_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic is_wr_r, is_wr_nxt;
    logic wait_one_r, wait_one_nxt;
    byte_t data_r, data_nxt;
    nibble_t out_r, out_nxt;
    logic oe_r, oe_nxt;
    logic rd_req_r, rd_req_nxt;
    logic wr_valid_r, wr_valid_nxt;
    logic size_rd_ok;

    // A start code this target serves
    function automatic logic start_known(input nibble_t code);
        start_known = (code == `NB_START_READ) || (code == `NB_START_WRITE);
    endfunction

    assign size_rd_ok = frame_s_r && (st_r == S_SIZE) && (nib_s_r == `NB_SIZE_ONE) && !is_wr_r;
    assign flush = frame_s_r && (st_r == S_START);
    assign drain_bus.ready = frame_s_r && (st_r == S_WAIT) && wait_one_r;

    // Outputs are computed with the next state so pins follow the state
    always_comb begin
        st_nxt = st_r;
        start_nxt = start_r;
        addr_nxt = addr_r;
        cnt_nxt = cnt_r;
        is_wr_nxt = is_wr_r;
        wait_one_nxt = wait_one_r;
        data_nxt = data_r;
        out_nxt = `NB_TURN_ONES;
        oe_nxt = 1'b0;
        rd_req_nxt = 1'b0;
        wr_valid_nxt = 1'b0;
        if (!frame_s_r) begin
            // Abort or start: release and keep the latest start nibble
            st_nxt = S_START; // RULE_18 RULE_01
            start_nxt = nib_s_r; // RULE_02
        end else begin
            unique case (st_r)
                S_IDLE, S_SKIP: begin
                    st_nxt = st_r;
                end
                S_START: begin
                    // Strobe just rose: this nibble is the device select
                    if (start_known(start_r) && (nib_s_r == id_s_r)) begin // RULE_04 RULE_03
                        st_nxt = S_ADDR;
                        is_wr_nxt = (start_r == `NB_START_WRITE);
                        cnt_nxt = `NB_ADDR_FIRST;
                    end else begin
                        st_nxt = S_SKIP; // RULE_21
                    end
                end
                S_ADDR: begin
                    addr_nxt = {addr_r[23:0], nib_s_r}; // RULE_05
                    cnt_nxt = cnt_r + 3'h1;
                    if (cnt_r == `NB_ADDR_LAST) begin
                        st_nxt = S_SIZE;
                    end
                end
                S_SIZE: begin
                    if (nib_s_r != `NB_SIZE_ONE) begin
                        st_nxt = S_IDLE; // RULE_19 RULE_07
                    end else if (is_wr_r) begin
                        st_nxt = S_WLO;
                    end else begin
                        // Pin delay lands this exactly on the first wait clock
                        st_nxt = S_WAIT; // RULE_09
                        wait_one_nxt = 1'b0;
                        rd_req_nxt = 1'b1;
                        oe_nxt = 1'b1;
                        out_nxt = `NB_WAIT_SYNC; // RULE_10
                    end
                end
                S_WLO: begin
                    data_nxt[3:0] = nib_s_r;
                    st_nxt = S_WHI;
                end
                S_WHI: begin
                    data_nxt[7:4] = nib_s_r;
                    wr_valid_nxt = 1'b1; // RULE_17
                    st_nxt = S_READY_SYNC_CODE;
                    oe_nxt = 1'b1;
                    out_nxt = `NB_READY_SYNC;
                end
                S_WAIT: begin
                    wait_one_nxt = 1'b1;
                    oe_nxt = 1'b1;
                    // Slow core stretches the wait phase beyond two clocks
                    if (wait_one_r && drain_bus.valid) begin
                        data_nxt = drain_bus.data;
                        st_nxt = S_READY_SYNC_CODE;
                        out_nxt = `NB_READY_SYNC; // RULE_11
                    end else begin
                        out_nxt = `NB_WAIT_SYNC; // RULE_10
                    end
                end
                S_READY_SYNC_CODE: begin
                    oe_nxt = 1'b1;
                    if (is_wr_r) begin
                        st_nxt = S_TAR;
                        out_nxt = `NB_TURN_ONES;
                    end else begin
                        st_nxt = S_DLO;
                        out_nxt = data_r[3:0]; // RULE_12
                    end
                end
                S_DLO: begin
                    st_nxt = S_DHI;
                    oe_nxt = 1'b1;
                    out_nxt = data_r[7:4]; // RULE_12
                end
                S_DHI: begin
                    // One byte only: straight to turnaround
                    st_nxt = S_TAR; // RULE_13
                    oe_nxt = 1'b1;
                    out_nxt = `NB_TURN_ONES; // RULE_14
                end
                S_TAR: begin
                    st_nxt = S_IDLE; // RULE_14
                end
                default: begin
                    st_nxt = S_IDLE;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r <= S_IDLE;
            start_r <= 4'h0;
            addr_r <= 28'h0000000;
            cnt_r <= 3'h0;
            is_wr_r <= 1'b0;
            wait_one_r <= 1'b0;
            data_r <= 8'h00;
            out_r <= 4'hf;
            oe_r <= 1'b0;
            rd_req_r <= 1'b0;
            wr_valid_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            start_r <= start_nxt;
            addr_r <= addr_nxt;
            cnt_r <= cnt_nxt;
            is_wr_r <= is_wr_nxt;
            wait_one_r <= wait_one_nxt;
            data_r <= data_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            rd_req_r <= rd_req_nxt;
            wr_valid_r <= wr_valid_nxt;
        end
    end

    // Ports straight from flops; ready is the buffer's own gating flop,
    // so the core never sees ready on an edge where the buffer refuses
    assign o_nibble_bus = out_r;
    assign o_nibble_bus_oe = oe_r;
    assign o_rd_req = rd_req_r;
    assign o_mem_addr = addr_r;
    assign o_wr_valid = wr_valid_r;
    assign o_wr_data = data_r;
    assign o_rdata_ready = fill_bus.ready;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n_r);

    abort_release_a: assert property (!frame_s_r |=> !o_nibble_bus_oe && st_r == S_START) // RULE_18
        else $error("strobe low did not release bus");
    last_start_a: assert property ((st_r == S_START) && frame_s_r && (start_r == `NB_START_READ)
        && (nib_s_r == id_s_r) |=> st_r == S_ADDR && !is_wr_r) // RULE_02
        else $error("last start not taken");
    select_miss_a: assert property ((st_r == S_START) && frame_s_r && (nib_s_r != id_s_r)
        |=> (st_r == S_SKIP && !o_nibble_bus_oe) ##1 (!o_nibble_bus_oe)) // RULE_21
        else $error("mismatch not ignored");
    addr_shift_a: assert property ((st_r == S_ADDR) && frame_s_r
        |=> addr_r == {$past(addr_r[23:0]), $past(nib_s_r)}) // RULE_05
        else $error("address nibble order wrong");
    bad_size_a: assert property ((st_r == S_SIZE) && frame_s_r && (nib_s_r != `NB_SIZE_ONE)
        |=> st_r == S_IDLE && !o_nibble_bus_oe && !o_rd_req && !o_wr_valid) // RULE_19
        else $error("bad size answered");
    wait_two_a: assert property (size_rd_ok ##1 frame_s_r
        |=> o_nibble_bus_oe && o_nibble_bus == `NB_WAIT_SYNC && $past(o_nibble_bus) == `NB_WAIT_SYNC) // RULE_10
        else $error("fewer than two wait syncs");
    data_order_a: assert property ((st_r == S_READY_SYNC_CODE) && !is_wr_r && frame_s_r ##1 frame_s_r
        |-> o_nibble_bus == data_r[3:0] ##1 o_nibble_bus == data_r[7:4]) // RULE_12
        else $error("data nibbles out of order");
    turn_release_a: assert property ((st_r == S_DHI) && frame_s_r
        |=> o_nibble_bus_oe && o_nibble_bus == `NB_TURN_ONES ##1 !o_nibble_bus_oe) // RULE_14
        else $error("turnaround not driven then released");
    one_byte_a: assert property ((st_r == S_DHI) |=> st_r != S_WAIT && st_r != S_READY_SYNC_CODE) // RULE_13
        else $error("second byte started");
    write_single_a: assert property (o_wr_valid |=> !o_wr_valid) // RULE_17
        else $error("write longer than one byte");

    read_done_c: cover property ((st_r == S_DHI) ##1 (st_r == S_TAR) ##1 (st_r == S_IDLE));
    write_done_c: cover property (o_wr_valid ##1 (st_r == S_READY_SYNC_CODE) ##1 (st_r == S_TAR));
    abort_c: cover property ((st_r == S_WAIT) && !frame_s_r);
    long_wait_c: cover property ((st_r == S_WAIT) [*4]);
endmodule

// *** tb/host_bus_model.sv ***
// Host bus master model: drives strobe and nibble fields, records replies.
// Assumes the bench resolves the shared wire and feeds it back on i_wire.
`timescale 1ns/1ps
module host_bus_model
    import nbus_pkg::*;
(
    input wire logic i_clk,
    input wire nibble_t i_wire,
    input wire logic i_oe,
    output logic o_frame_strobe_n,
    output nibble_t o_nib,
    output logic o_en
);
    nibble_t obs_nib [1:48];
    logic obs_oe [1:48];

    initial begin
        o_frame_strobe_n = 1'b1;
        o_nib = 4'hf;
        o_en = 1'b1;
    end

    // ----------------------------------------------------------------
    // Frame driver, one field per clock
    // ----------------------------------------------------------------
    task automatic run(input int nst, input logic [11:0] starts, input logic low,
        input nibble_t id, input mem_addr_t addr, input nibble_t size,
        input logic wr, input byte_t wd, input int abort_at, input int ncyc);
        int k;
        logic seen;
        seen = 1'b0;
        // Start fields fill cycles 2 - nst to 1, so the last start is cycle 1
        for (int j = 1; j <= nst + ncyc; j++) begin
            @(posedge i_clk);
            #1;
            k = j - nst + 1;
            if (k >= 1) begin
                obs_nib[k] = i_wire;
                obs_oe[k] = i_oe;
            end
            seen = seen | i_oe;
            o_frame_strobe_n = 1'b1;
            o_en = 1'b1;
            if (k <= 1) begin
                o_frame_strobe_n = !low;
                o_nib = starts[4 * (nst - j) +: 4];
            end else if (k == 2) o_nib = id;
            else if (k <= 9) o_nib = addr[4 * (9 - k) +: 4];
            else if (k == 10) o_nib = size;
            else if (wr && k == 11) o_nib = wd[3:0];
            else if (wr && k == 12) o_nib = wd[7:4];
            else if (k == (wr ? 13 : 11)) o_nib = 4'hf;
            else if (!seen || i_oe) o_en = 1'b0;
            // Abort: strobe low with no start code behind it
            if (k == abort_at) begin
                o_frame_strobe_n = 1'b0;
                o_nib = 4'hf;
                o_en = 1'b1;
            end
        end
        @(posedge i_clk);
        #1;
        o_frame_strobe_n = 1'b1;
        o_en = 1'b1;
        o_nib = 4'hf;
    endtask
endmodule

// *** tb/nibble_bus_flash_read_cycle_test.sv ***
// Bench for the nibble bus target with a host model and a memory core model.
// Assumes the design package, interface and host model compile first.
`timescale 1ns/1ps
module nibble_bus_flash_read_cycle_test
    import nbus_pkg::*;
;
    logic i_clk, i_reset_n, frame_n, host_en, dut_oe, rd_req, rdata_valid, rdata_ready, wr_valid;
    nibble_t wire_nib, host_nib, dut_nib, strap, pat;
    mem_addr_t mem_addr, rd_addr, req_addr;
    byte_t rdata, wr_data, wr_seen;
    logic pend, took, rdy_seen, core_fill, filling;
    int core_delay, cnt, rd_cnt, wr_cnt, bad_count, comparisons, cycles;

    // Released bus shows a pattern that moves every cycle
    assign wire_nib = dut_oe ? dut_nib : (host_en ? host_nib : pat);

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    host_bus_model i_host (.i_clk(i_clk), .i_wire(wire_nib), .i_oe(dut_oe),
        .o_frame_strobe_n(frame_n), .o_nib(host_nib), .o_en(host_en));

    nibble_bus_target i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_frame_strobe_n(frame_n),
        .i_nibble_bus(wire_nib), .o_nibble_bus(dut_nib), .o_nibble_bus_oe(dut_oe),
        .i_strapped_identity(strap), .o_rd_req(rd_req), .o_mem_addr(mem_addr), .i_rdata(rdata),
        .i_rdata_valid(rdata_valid), .o_rdata_ready(rdata_ready), .o_wr_valid(wr_valid),
        .o_wr_data(wr_data));

    function automatic byte_t mem(input mem_addr_t a);
        return a[7:0] ^ 8'h3c;
    endfunction

    // ----------------------------------------------------------------
    // Memory core model and monitors, acting just after each edge
    // ----------------------------------------------------------------
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            complete_run();
        end
        #1;
        took = rdata_valid && rdy_seen;
        pat = pat + 4'h3;
        if (rd_req === 1'b1) begin
            rd_cnt++;
            rd_addr = mem_addr;
            req_addr = mem_addr;
            pend = 1'b1;
            cnt = core_delay;
        end
        if (wr_valid === 1'b1) begin
            wr_cnt++;
            wr_seen = wr_data;
        end
        if (core_fill) begin
            rdata_valid = 1'b1;
            rdata = 8'h11;
            filling = 1'b1;
        end else if (took || filling) begin
            rdata_valid = 1'b0;
            filling = 1'b0;
        end
        // Slow core holds the byte back to stretch the wait phase
        if (pend && cnt == 0) begin
            rdata = mem(req_addr);
            rdata_valid = 1'b1;
            pend = 1'b0;
        end else if (pend) cnt--;
        rdy_seen = rdata_ready;
    end

    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic int oe_count(input int a, input int b);
        int n;
        n = 0;
        for (int i = a; i <= b; i++) n += (i_host.obs_oe[i] === 1'b1);
        return n;
    endfunction

    task automatic read(input mem_addr_t a, input int ncyc, input int wmin, input int wmax);
        int k;
        int r0;
        r0 = rd_cnt;
        i_host.run(1, 12'h00d, 1'b1, strap, a, 4'h0, 1'b0, 8'h00, 0, ncyc);
        check(rd_cnt - r0, 1);
        check(rd_addr, a);
        check(i_host.obs_oe[12], 0);
        check(i_host.obs_oe[13], 1);
        k = 13;
        while (k < 40 && i_host.obs_nib[k] === 4'h5 && i_host.obs_oe[k] === 1'b1) k++;
        check(k - 13 >= wmin && k - 13 <= wmax, 1);
        check(i_host.obs_nib[k], 4'h0);
        check(i_host.obs_nib[k + 1], mem(a) & 8'h0f);
        check(i_host.obs_nib[k + 2], mem(a) >> 4);
        check(i_host.obs_nib[k + 3], 4'hf);
        check(i_host.obs_oe[k + 4], 0);
    endtask

    // Identity boundaries 0000 and 1111, prompt and slow core
    task automatic t_read;
        strap = 4'h0;
        repeat (4) @(posedge i_clk);
        read(28'h1234567, 24, 2, 2);
        strap = 4'hf;
        repeat (4) @(posedge i_clk);
        core_delay = 6;
        read(28'hfedcba8, 34, 3, 12);
        core_delay = 0;
        $display("test read done");
    endtask

    task automatic t_reject;
        int r0;
        r0 = rd_cnt;
        i_host.run(1, 12'h00d, 1'b1, ~strap, 28'h0000010, 4'h0, 1'b0, 8'h00, 0, 26);
        check(oe_count(1, 26), 0);
        for (int s = 1; s < 16; s++) begin
            i_host.run(1, 12'h00d, 1'b1, strap, 28'h0000020, s[3:0], 1'b0, 8'h00, 0, 24);
            check(oe_count(1, 24), 0);
        end
        check(rd_cnt - r0, 0);
        $display("test reject done");
    endtask

    task automatic t_starts;
        i_host.run(3, 12'he0d, 1'b1, strap, 28'h00abc01, 4'h0, 1'b0, 8'h00, 0, 24);
        check(i_host.obs_nib[17], mem(28'h00abc01) >> 4);
        i_host.run(2, 12'h0d3, 1'b1, strap, 28'h00abc02, 4'h0, 1'b0, 8'h00, 0, 24);
        check(oe_count(1, 24), 0);
        i_host.run(1, 12'h00d, 1'b0, strap, 28'h00abc03, 4'h0, 1'b0, 8'h00, 0, 24);
        check(oe_count(1, 24), 0);
        $display("test starts done");
    endtask

    // Strobe low in mid wait phase, then a clean read must still work
    task automatic t_abort;
        core_delay = 40;
        i_host.run(1, 12'h00d, 1'b1, strap, 28'h0000330, 4'h0, 1'b0, 8'h00, 16, 30);
        pend = 1'b0;
        core_delay = 0;
        check(i_host.obs_oe[16], 1);
        check(oe_count(19, 30), 0);
        read(28'h0000331, 24, 2, 2);
        $display("test abort done");
    endtask

    task automatic t_write;
        int w0;
        w0 = wr_cnt;
        i_host.run(1, 12'h00e, 1'b1, strap, 28'h00c0ffe, 4'h0, 1'b1, 8'ha7, 0, 22);
        check(wr_cnt - w0, 1);
        check(wr_seen, 8'ha7);
        check({i_host.obs_oe[15], i_host.obs_nib[15]}, 5'h10);
        check(i_host.obs_nib[16], 4'hf);
        check(i_host.obs_oe[17], 0);
        $display("test write done");
    endtask

    // Stale bytes in a full buffer must not leak into the next read
    task automatic t_fill;
        core_fill = 1'b1;
        repeat (8) @(posedge i_clk);
        #1;
        check(rdata_ready, 0);
        core_fill = 1'b0;
        read(28'h0000452, 24, 2, 2);
        $display("test fill done");
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        {i_reset_n, rdata_valid, pend, rdy_seen, core_fill, filling} = 6'h00;
        {rd_cnt, wr_cnt, bad_count, comparisons, cycles, core_delay, cnt} = '0;
        {rdata, wr_seen, pat, strap} = '0;
        {rd_addr, req_addr} = '0;
        repeat (6) @(posedge i_clk);
        #1;
        check(dut_oe, 0);
        i_reset_n = 1'b1;
        repeat (10) @(posedge i_clk);
        t_read();
        t_reject();
        t_starts();
        t_abort();
        t_write();
        t_fill();
        complete_run();
    end
endmodule
